// *** hw/ods_top.sv ***
/*
  Opcode decode slice with AXI4-Lite register access. Software loads an
  opcode, operand byte, accumulator, flags, PC and displacement, then
  starts one execution; results and the next PC read back.
  Assumes one clock, mclk, and an asynchronous active-low reset.
*/
module ods_top
  import ods_pkg::*;
#(
  parameter int ADDR_W       = 8,    // Bus address width
  parameter bit MINUS_ON_SET = 1'b1  // Minus branch polarity
)(
  input  wire logic              mclk,     // 40 MHz clock
  input  wire logic              arst_n,   // Async reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,   // Write address
  input  wire logic              awvalid,  // Write address valid
  output logic                   awready,  // Write address ready
  input  wire logic [31:0]       wdata,    // Write data
  input  wire logic [3:0]        wstrb,    // Write byte strobes
  input  wire logic              wvalid,   // Write data valid
  output logic                   wready,   // Write data ready
  output logic [1:0]             bresp,    // Write response
  output logic                   bvalid,   // Write response valid
  input  wire logic              bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,   // Read address
  input  wire logic              arvalid,  // Read address valid
  output logic                   arready,  // Read address ready
  output logic [31:0]            rdata,    // Read data
  output logic [1:0]             rresp,    // Read response
  output logic                   rvalid,   // Read data valid
  input  wire logic              rready    // Read data ready
);

  if (ADDR_W < 8) begin : g_chk
    $error("ods_top: ADDR_W must be at least 8");
  end

  logic [ADDR_W-1:0] awAddr_r;
  logic              awHave_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              wHave_r;
  logic [7:0]        opcode_r;
  logic [7:0]        mem_r;
  logic [7:0]        acc_r;
  logic [7:0]        flags_r;
  logic [15:0]       pc_r;
  logic [7:0]        disp_r;
  logic              go_r;
  logic              done_r;
  logic              taken_r;
  logic              illegal_r;
  logic [15:0]       newPc_r;
  ods_dec_s          dec;
  ods_alu_s          alu;

  ods_decode u_dec (
    .opcode (opcode_r),
    .dec    (dec)
  );

  ods_alu #(.MINUS_ON_SET(MINUS_ON_SET)) u_alu (
    .dec   (dec),
    .acc   (acc_r),
    .mem   (mem_r),
    .flags (flags_r),
    .out   (alu)
  );

  // Write channel handshake and decode
  wire              awTake   = awvalid & awready;
  wire              wTake    = wvalid & wready;
  wire              doWrite  = awHave_r & wHave_r & ~bvalid;
  wire              awHave_nxt = (awHave_r | awTake) & ~doWrite;
  wire              wHave_nxt  = (wHave_r | wTake) & ~doWrite;
  wire [ADDR_W-1:0] wa       = awAddr_r;
  wire              wSelCtrl = (wa == ADDR_W'(OFF_CTRL));
  wire              wSelOpc  = (wa == ADDR_W'(OFF_OPCODE));
  wire              wSelMem  = (wa == ADDR_W'(OFF_MEM));
  wire              wSelAcc  = (wa == ADDR_W'(OFF_ACC));
  wire              wSelFlg  = (wa == ADDR_W'(OFF_FLAGS));
  wire              wSelPc   = (wa == ADDR_W'(OFF_PC));
  wire              wSelDisp = (wa == ADDR_W'(OFF_DISP));
  wire              wSelRo   = (wa == ADDR_W'(OFF_STATUS)) | (wa == ADDR_W'(OFF_NEWPC));
  wire              wMapped  = wSelCtrl | wSelOpc | wSelMem | wSelAcc | wSelFlg | wSelPc
                               | wSelDisp | wSelRo;
  wire [7:0]        wB0      = wStrb_r[0] ? wData_r[7:0] : 8'h00;
  wire              wB0En    = doWrite & wStrb_r[0];
  wire              wB1En    = doWrite & wStrb_r[1];
  wire              clrReq   = wB0En & wSelCtrl & wB0[CTRL_CLR];

  // Execution step decode
  wire              exec     = go_r & (dec.op != OP_NONE);
  wire              wrAcc    = exec & ((dec.op == OP_ADC) | (dec.op == OP_AND)
                               | ((dec.op == OP_SHL) & dec.accMode));
  wire              wrMem    = exec & (dec.op == OP_SHL) & ~dec.accMode;
  wire [15:0]       dispExt  = {{8{disp_r[7]}}, disp_r};
  wire [15:0]       nextPc   = pc_r + {14'h0000, dec.len};
  wire [15:0]       brPc     = alu.taken ? nextPc + dispExt : nextPc;

  // Write address and data holding
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
    end else begin
      awHave_r <= awHave_nxt;
      wHave_r  <= wHave_nxt;
      awready  <= ~awHave_nxt;
      wready   <= ~wHave_nxt;
      if (awTake) awAddr_r <= awaddr;
      if (wTake) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      bvalid <= doWrite | (bvalid & ~bready);
      if (doWrite) bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Operand registers; an execution result wins over a bus write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_r <= 8'h00;
      mem_r    <= 8'h00;
      acc_r    <= 8'h00;
      disp_r   <= 8'h00;
      pc_r     <= 16'h0000;
    end else begin
      if (wB0En & wSelOpc) opcode_r <= wData_r[7:0];
      if (wB0En & wSelDisp) disp_r <= wData_r[7:0];
      if (wB0En & wSelPc) pc_r[7:0] <= wData_r[7:0];
      if (wB1En & wSelPc) pc_r[15:8] <= wData_r[15:8];
      if (wrMem) mem_r <= alu.res;
      else if (wB0En & wSelMem) mem_r <= wData_r[7:0];
      if (wrAcc) acc_r <= alu.res;
      else if (wB0En & wSelAcc) acc_r <= wData_r[7:0];
    end
  end

  // Flags, start pulse and result status
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r   <= FLAGS_RST;
      go_r      <= 1'b0;
      done_r    <= 1'b0;
      taken_r   <= 1'b0;
      illegal_r <= 1'b0;
      newPc_r   <= 16'h0000;
    end else begin
      go_r <= wB0En & wSelCtrl & wB0[CTRL_GO];
      // bits 5 and 4 forced on
      if (exec) flags_r <= alu.flags;
      else if (wB0En & wSelFlg) flags_r <= wData_r[7:0] | FLAGS_ONES;
      // Set wins over clear
      done_r <= go_r | (done_r & ~clrReq);
      if (go_r) begin
        taken_r   <= alu.taken;
        illegal_r <= (dec.op == OP_NONE);
        newPc_r   <= (dec.op == OP_NONE) ? pc_r : brPc;
      end
    end
  end

  // Read address decode and data selection
  wire       arTake   = arvalid & arready;
  wire       rvHold   = rvalid & ~rready;
  wire       rSelCtrl = (araddr == ADDR_W'(OFF_CTRL));
  wire       rSelOpc  = (araddr == ADDR_W'(OFF_OPCODE));
  wire       rSelMem  = (araddr == ADDR_W'(OFF_MEM));
  wire       rSelAcc  = (araddr == ADDR_W'(OFF_ACC));
  wire       rSelFlg  = (araddr == ADDR_W'(OFF_FLAGS));
  wire       rSelPc   = (araddr == ADDR_W'(OFF_PC));
  wire       rSelDisp = (araddr == ADDR_W'(OFF_DISP));
  wire       rSelStat = (araddr == ADDR_W'(OFF_STATUS));
  wire       rSelNpc  = (araddr == ADDR_W'(OFF_NEWPC));
  wire       rMapped  = rSelCtrl | rSelOpc | rSelMem | rSelAcc | rSelFlg | rSelPc
                        | rSelDisp | rSelStat | rSelNpc;
  wire [2:0] statBits = {illegal_r, taken_r, done_r};
  wire [31:0] rMux =
      rSelOpc  ? {24'h000000, opcode_r} :
      rSelMem  ? {24'h000000, mem_r} :
      rSelAcc  ? {24'h000000, acc_r} :
      rSelFlg  ? {24'h000000, flags_r} :
      rSelPc   ? {16'h0000, pc_r} :
      rSelDisp ? {24'h000000, disp_r} :
      rSelStat ? {29'h00000000, statBits} :
      rSelNpc  ? {16'h0000, newPc_r} : 32'h0000_0000;

  // Read channel
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      rvalid  <= arTake | rvHold;
      arready <= ~(arTake | rvHold);
      if (arTake) begin
        rdata <= rMux;
        rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Helper views for the checks below
  wire       cFlag  = flags_r[FLG_C];
  wire       zFlag  = flags_r[FLG_Z];
  wire       nFlag  = flags_r[FLG_N];
  wire       vFlag  = flags_r[FLG_V];
  wire       selBit = mem_r[dec.bitSel];
  wire [1:0] memTop = mem_r[7:6];
  wire [8:0] addSum = {1'b0, acc_r} + {1'b0, mem_r} + {8'h00, cFlag};

  property p_adc;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_ADC |=> acc_r == $past(addSum[7:0]) && cFlag == $past(addSum[8]);
  endproperty
  a_adc: assert property (p_adc) else $error("add result or carry wrong");

  property p_and;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_AND
      |=> acc_r == ($past(acc_r) & $past(mem_r)) && cFlag == $past(cFlag)
          && vFlag == $past(vFlag);
  endproperty
  a_and: assert property (p_and) else $error("and result or untouched flag wrong");

  property p_shl;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_SHL && dec.accMode
      |=> cFlag == $past(acc_r[7]) && acc_r[0] == 1'b0 && acc_r[7:1] == $past(acc_r[6:0]);
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");

  property p_bbr;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_BBR |=> taken_r == !$past(selBit) && $stable(flags_r);
  endproperty
  a_bbr: assert property (p_bbr) else $error("branch on clear bit wrong");

  property p_bbs;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_BBS |=> taken_r == $past(selBit) && $stable(flags_r);
  endproperty
  a_bbs: assert property (p_bbs) else $error("branch on set bit wrong");

  property p_bfl;
    @(posedge mclk) disable iff (!arst_n)
      go_r && (opcode_r == 8'h90 || opcode_r == 8'hb0 || opcode_r == 8'hf0)
      |=> $stable(flags_r) && taken_r == ($past(opcode_r) == 8'h90 ? !$past(cFlag) :
          $past(opcode_r) == 8'hb0 ? $past(cFlag) : $past(zFlag));
  endproperty
  a_bfl: assert property (p_bfl) else $error("flag branch wrong");

  property p_minus;
    @(posedge mclk) disable iff (!arst_n)
      go_r && opcode_r == 8'h30 |=> taken_r == ($past(nFlag) == MINUS_ON_SET) && $stable(flags_r);
  endproperty
  a_minus: assert property (p_minus) else $error("minus branch wrong");

  property p_bit;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_BIT |=> {nFlag, vFlag} == $past(memTop) && $stable(acc_r);
  endproperty
  a_bit: assert property (p_bit) else $error("bit test flags wrong");

  property p_ones;
    @(posedge mclk) disable iff (!arst_n)
      arTake && rSelFlg |=> rdata[5:4] == 2'b11;
  endproperty
  a_ones: assert property (p_ones) else $error("status bits 5 and 4 not one");

  property p_len3;
    @(posedge mclk) disable iff (!arst_n)
      go_r && (dec.op == OP_BBR || dec.op == OP_BBS) && !alu.taken
      |=> newPc_r == $past(pc_r) + 16'h0003;
  endproperty
  a_len3: assert property (p_len3) else $error("bit branch length not three");

  property p_rel;
    @(posedge mclk) disable iff (!arst_n)
      go_r && dec.op == OP_BFLG && alu.taken
      |=> newPc_r == $past(pc_r) + 16'h0002 + $past(dispExt);
  endproperty
  a_rel: assert property (p_rel) else $error("branch target wrong");

endmodule

// *** hw/ods_pkg.sv ***
/*
  Shared constants and types of the opcode decode slice: register
  offsets, field positions, reset values, operation and condition codes.
  Assumes a single 40 MHz clock and an AXI4-Lite register bus.
*/
// What this block does
// - Add with carry: A+M+C into A, nine opcodes, sets N V Z C.
// - AND: A and M into A, nine opcodes, sets only N and Z.
// - Shift left: bit 7 into C, zero into bit 0, sets N Z C.
// - Zero-page bit branch on clear, opcodes 0F..7F, flags untouched.
// - Zero-page bit branch on set, opcodes 8F..FF, flags untouched.
// - Carry clear 90, carry set B0, equal F0 branches; flags untouched.
// - Minus branch at 30 on N, flags untouched; polarity is a parameter.
// - Bit test: A and M sets Z, M bits 7 and 6 go to N and V.
// - Status layout N7 V6 1 1 D3 I2 Z1 C0, bits 5 and 4 read one.
package ods_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OPCODE = 8'h04;
  localparam logic [7:0] OFF_MEM    = 8'h08;
  localparam logic [7:0] OFF_ACC    = 8'h0c;
  localparam logic [7:0] OFF_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_PC     = 8'h14;
  localparam logic [7:0] OFF_DISP   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_NEWPC  = 8'h20;

  // Control and status bit positions
  localparam int CTRL_GO      = 0;
  localparam int CTRL_CLR     = 1;
  localparam int STAT_DONE    = 0;
  localparam int STAT_TAKEN   = 1;
  localparam int STAT_ILLEGAL = 2;

  // Status flag positions
  localparam int FLG_N = 7;
  localparam int FLG_V = 6;
  localparam int FLG_D = 3;
  localparam int FLG_I = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_ONES = 8'h30;
  localparam logic [7:0] FLAGS_RST  = 8'h30;

  // Instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_ADC = 3'b001, OP_AND = 3'b010, OP_SHL = 3'b011,
    OP_BBR  = 3'b100, OP_BBS = 3'b101, OP_BFLG = 3'b110, OP_BIT = 3'b111
  } ods_op_e;

  typedef enum logic [1:0] {
    CND_CC = 2'b00, CND_CS = 2'b01, CND_EQ = 2'b10, CND_MI = 2'b11
  } ods_cond_e;

  typedef struct packed {
    ods_op_e    op;
    logic       accMode;
    logic [1:0] len;
    ods_cond_e  cond;
    logic [2:0] bitSel;
  } ods_dec_s;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
    logic       taken;
  } ods_alu_s;

endpackage

// *** hw/ods_decode.sv ***
/*
  Opcode decoder: maps an opcode byte onto operation, length, branch
  condition and tested bit. Purely combinational; fed from a register.
*/
module ods_decode
  import ods_pkg::*;
(
  input  wire logic [7:0] opcode,  // Fetched opcode byte
  output ods_dec_s        dec      // Decoded fields
);

  // Bit-branch column is recognised by its low nibble, rest by table
  always_comb begin
    dec = '{op: OP_NONE, accMode: 1'b0, len: LEN_1, cond: CND_CC, bitSel: opcode[6:4]};
    if (opcode[3:0] == 4'hf) begin
      dec.op  = opcode[7] ? OP_BBS : OP_BBR;
      dec.len = LEN_3;
    end else begin
      unique case (opcode)
        8'h6d, 8'h7d, 8'h79: begin dec.op = OP_ADC; dec.len = LEN_3; end
        8'h69, 8'h65, 8'h61, 8'h75, 8'h72, 8'h71: begin
          dec.op  = OP_ADC;
          dec.len = LEN_2;
        end
        8'h2d, 8'h3d, 8'h39: begin dec.op = OP_AND; dec.len = LEN_3; end
        8'h29, 8'h25, 8'h21, 8'h35, 8'h32, 8'h31: begin
          dec.op  = OP_AND;
          dec.len = LEN_2;
        end
        8'h0e, 8'h1e: begin dec.op = OP_SHL; dec.len = LEN_3; end
        8'h06, 8'h16: begin dec.op = OP_SHL; dec.len = LEN_2; end
        8'h0a: begin dec.op = OP_SHL; dec.accMode = 1'b1; end
        8'h2c, 8'h3c: begin dec.op = OP_BIT; dec.len = LEN_3; end
        8'h89, 8'h24, 8'h34: begin dec.op = OP_BIT; dec.len = LEN_2; end
        8'h90: begin dec.op = OP_BFLG; dec.len = LEN_2; dec.cond = CND_CC; end
        8'hb0: begin dec.op = OP_BFLG; dec.len = LEN_2; dec.cond = CND_CS; end
        8'hf0: begin dec.op = OP_BFLG; dec.len = LEN_2; dec.cond = CND_EQ; end
        8'h30: begin dec.op = OP_BFLG; dec.len = LEN_2; dec.cond = CND_MI; end
        default: dec.op = OP_NONE;
      endcase
    end
  end

endmodule

// *** hw/ods_alu.sv ***
/*
  Operation unit: result byte, new status flags and branch decision
  for one decoded instruction. Combinational; binary arithmetic only.
*/
module ods_alu
  import ods_pkg::*;
#(
  parameter bit MINUS_ON_SET = 1'b1  // Minus branch taken when N is one
)(
  input  wire ods_dec_s   dec,     // Decoded instruction
  input  wire logic [7:0] acc,     // Accumulator
  input  wire logic [7:0] mem,     // Memory operand byte
  input  wire logic [7:0] flags,   // Current status flags
  output ods_alu_s        out      // Result, flags, branch decision
);

  logic [8:0] sum;
  logic [7:0] shSrc;
  logic [7:0] andVal;

  // Operand paths; only andVal is shared, by AND and bit test
  assign sum    = {1'b0, acc} + {1'b0, mem} + {8'h00, flags[FLG_C]};
  assign shSrc  = dec.accMode ? acc : mem;
  assign andVal = acc & mem;

  // Per-operation result and flag effects; untouched flags pass through
  always_comb begin
    out       = '{res: acc, flags: flags, taken: 1'b0};
    unique case (dec.op)
      OP_ADC: begin
        out.res          = sum[7:0];
        out.flags[FLG_C] = sum[8];
        out.flags[FLG_V] = ~(acc[7] ^ mem[7]) & (acc[7] ^ sum[7]);
        out.flags[FLG_N] = sum[7];
        out.flags[FLG_Z] = (sum[7:0] == 8'h00);
      end
      OP_AND: begin
        out.res          = andVal;
        out.flags[FLG_N] = andVal[7];
        out.flags[FLG_Z] = (andVal == 8'h00);
      end
      OP_SHL: begin
        out.res          = {shSrc[6:0], 1'b0};
        out.flags[FLG_C] = shSrc[7];
        out.flags[FLG_N] = shSrc[6];
        out.flags[FLG_Z] = (shSrc[6:0] == 7'h00);
      end
      OP_BBR: out.taken = ~mem[dec.bitSel];
      OP_BBS: out.taken = mem[dec.bitSel];
      OP_BFLG: begin
        unique case (dec.cond)
          CND_CC: out.taken = ~flags[FLG_C];
          CND_CS: out.taken = flags[FLG_C];
          CND_EQ: out.taken = flags[FLG_Z];
          CND_MI: out.taken = (flags[FLG_N] == MINUS_ON_SET);
        endcase
      end
      OP_BIT: begin
        out.flags[FLG_Z] = (andVal == 8'h00);
        out.flags[FLG_N] = mem[7];
        out.flags[FLG_V] = mem[6];
      end
      OP_NONE: out.taken = 1'b0;
    endcase
    out.flags = out.flags | FLAGS_ONES;
  end

endmodule

// *** sim/ods_prog_mem.sv ***
/*
  Program memory model: sixteen zero-page bit branches of three bytes
  each, followed by the zero-page bytes that they test.
  Assumes the bench reads it combinationally; it has no write port.
*/
module ods_prog_mem (
  input  wire logic [15:0] addr,  // Byte address
  output logic      [7:0]  data   // Byte at that address
);
  logic [7:0] mem [256];

  // Fill with the address XOR 5A, then lay out the branches and tested bytes
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
    for (int k = 0; k < 16; k++) begin
      mem[k*3]     = 8'(k * 16 + 15);
      mem[k*3+1]   = 8'(8'h80 + k);
      mem[k*3+2]   = 8'(8'h80 + k * 9);
      mem[8'h80+k] = k[0] ? ~(8'h01 << (k % 8)) : (8'h01 << (k % 8));
    end
  end

  // Plain byte read
  assign data = mem[addr[7:0]];
endmodule

// *** sim/testbench.sv ***
/*
  Testbench: loads instructions into the decode slice over AXI4-Lite,
  starts each one and compares result registers with worked-out values.
  Assumes ods_top with default parameters and the ods_prog_mem model.
*/
module testbench import ods_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0, arst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] pmAddr = 16'h0;
  logic [7:0]  pmData;
  int          failures = 0, compares = 0;
  logic [7:0]  adcOp [9] = '{8'h6d, 8'h7d, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75, 8'h72, 8'h71};
  logic [7:0]  andOp [9] = '{8'h2d, 8'h3d, 8'h39, 8'h29, 8'h25, 8'h21, 8'h35, 8'h32, 8'h31};
  int          lenTab [9] = '{3, 3, 3, 2, 2, 2, 2, 2, 2};
  logic [7:0]  shlOp [5] = '{8'h0e, 8'h1e, 8'h0a, 8'h06, 8'h16};
  int          shlLen [5] = '{3, 3, 1, 2, 2};
  logic [7:0]  bitOp [5] = '{8'h2c, 8'h3c, 8'h89, 8'h24, 8'h34};
  int          bitLen [5] = '{3, 3, 2, 2, 2};
  logic [7:0]  brOp [8] = '{8'h90, 8'h90, 8'hb0, 8'hb0, 8'hf0, 8'hf0, 8'h30, 8'h30};
  logic [7:0]  brFlg [8] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h80, 8'h00};

  always #12.5 mclk = ~mclk;

  ods_top #(.ADDR_W(8), .MINUS_ON_SET(1'b1)) DUT (
    .mclk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  ods_prog_mem u_prog (.addr(pmAddr), .data(pmData));

  // Count a comparison and report a mismatch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One AXI4-Lite write; offsets above OFF_NEWPC expect an error response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, (a > OFF_NEWPC) ? RESP_SLVERR : RESP_OKAY);
    if (n == 40) failures++;
  endtask

  // One AXI4-Lite read, compared with an expected word
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk(rdata, exp);
    chk(rresp, (a > OFF_NEWPC) ? RESP_SLVERR : RESP_OKAY);
    rready <= 1'b0;
    if (n == 40) failures++;
  endtask

  // Fetch one byte from the program memory model
  task automatic pm(input logic [15:0] a, output logic [7:0] d);
    pmAddr = a;
    #1;
    d = pmData;
  endtask

  // Load an instruction, start it, and compare every result register
  task automatic run(input logic [7:0] op, acc, mem, flg, disp, input logic [15:0] pc,
                     input logic [7:0] eAcc, eMem, eFlg, input logic tk, input int len,
                     input logic ill);
    logic [15:0] npc;
    npc = pc + 16'(len) + (tk ? {{8{disp[7]}}, disp} : 16'h0000);
    wr(OFF_OPCODE, {24'h0, op});
    wr(OFF_ACC, {24'h0, acc});
    wr(OFF_MEM, {24'h0, mem});
    wr(OFF_FLAGS, {24'h0, flg});
    wr(OFF_DISP, {24'h0, disp});
    wr(OFF_PC, {16'h0, pc});
    wr(OFF_CTRL, 32'h1);
    rc(OFF_STATUS, {29'h0, ill, tk, 1'b1});
    rc(OFF_ACC, {24'h0, eAcc});
    rc(OFF_MEM, {24'h0, eMem});
    rc(OFF_FLAGS, {24'h0, eFlg});
    rc(OFF_NEWPC, {16'h0, npc});
    $display("Test of opcode %h ended", op);
  endtask

  // Cut a hang short
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [7:0] op, zp, dsp, tb;
    logic       tk;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rc(OFF_FLAGS, 32'h30);
    wr(8'h40, 32'h1);
    rc(8'h40, 32'h0);
    for (int k = 0; k < 9; k++) begin
      run(adcOp[k], 8'h7f, 8'h01, 8'h00, 8'h00, 16'h0200, 8'h80, 8'h01, 8'hf0, 0, lenTab[k], 0);
      run(andOp[k], 8'hf0, 8'h8f, 8'h41, 8'h00, 16'h0200, 8'h80, 8'h8f, 8'hf1, 0, lenTab[k], 0);
    end
    run(8'h69, 8'hff, 8'h00, 8'h01, 8'h00, 16'h0300, 8'h00, 8'h00, 8'h33, 0, 2, 0);
    for (int k = 0; k < 5; k++) begin
      if (shlOp[k] == 8'h0a) begin
        run(shlOp[k], 8'h81, 8'h81, 8'h80, 8'h00, 16'h0400, 8'h02, 8'h81, 8'h31, 0, 1, 0);
      end else begin
        run(shlOp[k], 8'h81, 8'h81, 8'h80, 8'h00, 16'h0400, 8'h81, 8'h02, 8'h31, 0, shlLen[k], 0);
      end
      run(bitOp[k], 8'h3f, 8'hc0, 8'h03, 8'h00, 16'h0500, 8'h3f, 8'hc0, 8'hf3, 0, bitLen[k], 0);
    end
    run(8'h0a, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0400, 8'h00, 8'h00, 8'h33, 0, 1, 0);
    for (int k = 0; k < 16; k++) begin
      pm(16'(k * 3), op);
      pm(16'(k * 3 + 1), zp);
      pm(16'(k * 3 + 2), dsp);
      pm({8'h00, zp}, tb);
      // Taken when the selected bit equals the opcode's top bit
      tk = (tb[op[6:4]] == op[7]);
      run(op, 8'ha5, tb, 8'hcf, dsp, 16'(k * 3), 8'ha5, tb, 8'hff, tk, 3, 0);
    end
    for (int k = 0; k < 8; k++) begin
      run(brOp[k], 8'h00, 8'h00, brFlg[k], 8'h80, 16'h0100, 8'h00, 8'h00, brFlg[k] | 8'h30,
          !k[0], 2, 0);
    end
    run(8'hea, 8'h11, 8'h22, 8'h00, 8'h05, 16'h0600, 8'h11, 8'h22, 8'h30, 0, 0, 1);
    wr(OFF_STATUS, 32'h0);
    rc(OFF_STATUS, 32'h5);
    // Clearing done keeps the illegal and taken bits; control reads back zero
    wr(OFF_CTRL, 32'h2);
    rc(OFF_STATUS, 32'h4);
    rc(OFF_CTRL, 32'h0);
    $display("Test of status clear ended");
    report_and_stop();
  end
endmodule
